/* File: hw/atdt_regs.sv */
// apb register block for input b trim, dither, sample marker and serial enable
`timescale 1ns/1ns
`include "atdt_cfg.svh"

// Notes on behaviour
// RQ1 - input b trim loads factory value, rw
// RQ2 - dither bit0 turns dither on, default on
// RQ3 - dither bit1 picks large amplitude
// RQ4 - dither bit2 routes rounding error to offset
// RQ5 - marker enable puts timestamp on sample lsb
// RQ6 - timestamp latency equals analog input latency
// RQ7 - software also enables sync receiver
// RQ8 - 8-bit samples: lsb becomes marker
// RQ9 - 12-bit samples: lsb becomes marker
// RQ10 - lane alignment always reports zero control bits
// RQ11 - serial enable at 0x200, resets to 0x01
// RQ12 - serial disabled: held reset, powered down, gated
// RQ13 - software disables serial before changing link settings
// RQ14 - software writes zero to reserved bits
module atdt_regs #(
    parameter int CONV_LAT = 4,
    parameter int K_FRAMES = 32
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`ATDT_ADDR_W-1:0]  paddr,
    input  wire logic [`ATDT_DATA_W-1:0]  pwdata,
    input  wire logic [3:0]               pstrb,
    output logic      [`ATDT_DATA_W-1:0]  prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic [7:0]               trim_fuse_val,
    input  wire logic                     sync_receiver_on,
    input  wire logic                     sysref_pulse,
    input  wire atdt_pkg::atdt_sample_t   sample_in,
    input  wire logic                     timestamp_in,
    output logic      [7:0]               input_b_termination_trim,
    output atdt_pkg::atdt_dither_t        dither,
    output atdt_pkg::atdt_serial_t        serial,
    output atdt_pkg::atdt_sample_t        sample_out,
    output logic                          lmfc_boundary,
    output logic      [1:0]               ilas_cs_count
);

    localparam int KW = (K_FRAMES > 1) ? $clog2(K_FRAMES) : 1;
    localparam logic [KW-1:0] K_LAST = KW'(K_FRAMES - 1);

    logic [7:0]    trim_r;
    logic [7:0]    dith_r;
    logic [7:0]    mark_r;
    logic [7:0]    ser_r;
    logic          trim_loaded_r;
    logic [KW-1:0] lmfc_cnt_r;
    logic          setup;
    logic          acc_done;
    logic          wr;
    logic [4:0]    hit;
    logic [7:0]    rd_byte;
    logic [7:0]    stat;

    // ****************************************************************
    // address decode
    // ****************************************************************
    // one-hot: trim, dither, marker, status, serial
    function automatic logic [4:0] decode(input logic [`ATDT_ADDR_W-1:0] a);
        logic [4:0] h;
        h    = '0;
        h[0] = (a == atdt_pkg::atdt_byte_addr(`ATDT_IDX_TRIM));
        h[1] = (a == atdt_pkg::atdt_byte_addr(`ATDT_IDX_DITH));
        h[2] = (a == atdt_pkg::atdt_byte_addr(`ATDT_IDX_MARK));
        h[3] = (a == atdt_pkg::atdt_byte_addr(`ATDT_IDX_STAT));
        h[4] = (a == atdt_pkg::atdt_byte_addr(`ATDT_IDX_SER));
        return h;
    endfunction

    assign setup    = psel & ~penable;
    assign acc_done = psel & penable & pready;
    // only byte lane 0 holds data, upper lanes ignored
    assign wr       = acc_done & pwrite & pstrb[0];
    assign hit      = decode(paddr);

    // status: serial active, trim loaded, marker on without receiver
    always_comb begin
        stat = 8'h00;
        stat[`ATDT_STAT_ACT_BIT]  = ser_r[`ATDT_SER_EN_BIT];
        stat[`ATDT_STAT_LOAD_BIT] = trim_loaded_r;
        stat[`ATDT_STAT_RX_BIT]   = mark_r[`ATDT_MARK_EN_BIT] & ~sync_receiver_on; // RQ7
    end

    always_comb begin
        rd_byte = 8'h00;
        unique case (1'b1)
            hit[0]:  rd_byte = trim_r;
            hit[1]:  rd_byte = dith_r;
            hit[2]:  rd_byte = mark_r;
            hit[3]:  rd_byte = stat;
            hit[4]:  rd_byte = ser_r;
            default: rd_byte = 8'h00;
        endcase
    end

    // ****************************************************************
    // apb answer, one access cycle, data registered in setup
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= {24'h000000, rd_byte};
            pslverr <= ~(|hit);
        end else if (acc_done) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end
    end

    // ****************************************************************
    // input b termination trim
    // ****************************************************************
    // factory value caught on the first edge after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_loaded_r <= 1'b0;
        end else begin
            trim_loaded_r <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_r <= `ATDT_RST_TRIM;
        end else if (!trim_loaded_r) begin
            trim_r <= trim_fuse_val; // RQ1
        end else if (wr && hit[0]) begin
            trim_r <= pwdata[7:0]; // RQ1
        end
    end

    // ****************************************************************
    // dither, marker and serial enable registers
    // ****************************************************************
    // reserved bits are stored and read back as written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dith_r <= `ATDT_RST_DITH; // RQ2
        end else if (wr && hit[1]) begin
            dith_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mark_r <= `ATDT_RST_MARK;
        end else if (wr && hit[2]) begin
            mark_r <= pwdata[7:0]; // RQ5
        end
    end

    // no interlock against link changes while enabled, software orders it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ser_r <= `ATDT_RST_SER; // RQ11
        end else if (wr && hit[4]) begin
            ser_r <= pwdata[7:0]; // RQ13
        end
    end

    // ****************************************************************
    // analog and serial control outputs
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_b_termination_trim <= `ATDT_RST_TRIM;
            dither                   <= '0;
        end else begin
            input_b_termination_trim <= trim_r;
            dither.on                <= dith_r[`ATDT_DITH_ON_BIT]; // RQ2
            dither.amp_large         <= dith_r[`ATDT_DITH_AMP_BIT]; // RQ3
            dither.err_to_offset     <= dith_r[`ATDT_DITH_ERR_BIT]; // RQ4
        end
    end

    // reset state is the disabled state until the register is seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial.block_reset_n <= 1'b0;
            serial.ser_powerdown <= 1'b1;
            serial.clk_gate_en   <= 1'b0;
        end else begin
            serial.block_reset_n <= ser_r[`ATDT_SER_EN_BIT]; // RQ12
            serial.ser_powerdown <= ~ser_r[`ATDT_SER_EN_BIT]; // RQ12
            serial.clk_gate_en   <= ser_r[`ATDT_SER_EN_BIT]; // RQ12
        end
    end

    // ****************************************************************
    // multiframe counter
    // ****************************************************************
    // reference pulses ignored while disabled, counter parked at zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lmfc_cnt_r <= '0;
        end else if (!ser_r[`ATDT_SER_EN_BIT]) begin
            lmfc_cnt_r <= '0; // RQ12
        end else if (sysref_pulse || lmfc_cnt_r == K_LAST) begin
            lmfc_cnt_r <= '0;
        end else begin
            lmfc_cnt_r <= lmfc_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lmfc_boundary <= 1'b0;
        end else begin
            lmfc_boundary <= ser_r[`ATDT_SER_EN_BIT] && lmfc_cnt_r == K_LAST && !sysref_pulse;
        end
    end

    // marker never advertised, whatever the enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ilas_cs_count <= `ATDT_CS_ADVERTISED;
        end else begin
            ilas_cs_count <= `ATDT_CS_ADVERTISED; // RQ10
        end
    end

    // ****************************************************************
    // sample marker path
    // ****************************************************************
    // timestamp receiver assumed on when the marker is used
    atdt_marker #(
        .LAT(CONV_LAT)
    ) u_marker (
        .pclk        (pclk),
        .presetn     (presetn),
        .enable      (mark_r[`ATDT_MARK_EN_BIT]),
        .sample_in   (sample_in),
        .timestamp_in(timestamp_in),
        .sample_out  (sample_out)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_trim_write;
        @(posedge pclk) disable iff (!presetn)
        wr && hit[0] && trim_loaded_r |=> ##1 input_b_termination_trim == $past(pwdata[7:0], 2);
    endproperty
    a_trim_write: assert property (p_trim_write) // RQ1
        else $error("trim write not reflected on output");

    property p_trim_fuse;
        @(posedge pclk) disable iff (!presetn)
        $rose(trim_loaded_r) |-> trim_r == $past(trim_fuse_val);
    endproperty
    a_trim_fuse: assert property (p_trim_fuse) // RQ1
        else $error("factory trim not loaded after reset");

    property p_dith_on;
        @(posedge pclk) disable iff (!presetn)
        wr && hit[1] |=> ##1 dither.on == $past(pwdata[0], 2);
    endproperty
    a_dith_on: assert property (p_dith_on) // RQ2
        else $error("dither enable does not follow register");

    property p_dith_amp;
        @(posedge pclk) disable iff (!presetn)
        wr && hit[1] |=> ##1 dither.amp_large == $past(pwdata[1], 2);
    endproperty
    a_dith_amp: assert property (p_dith_amp) // RQ3
        else $error("dither amplitude does not follow register");

    property p_dith_err;
        @(posedge pclk) disable iff (!presetn)
        wr && hit[1] |=> ##1 dither.err_to_offset == $past(pwdata[2], 2);
    endproperty
    a_dith_err: assert property (p_dith_err) // RQ4
        else $error("rounding error routing does not follow register");

    property p_cs_zero;
        @(posedge pclk) disable iff (!presetn)
        $rose(mark_r[0]) |-> ##[0:4] ilas_cs_count == 2'h0;
    endproperty
    a_cs_zero: assert property (p_cs_zero) // RQ10
        else $error("control bit count advertised");

    property p_ser_reset;
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> ser_r == 8'h01;
    endproperty
    a_ser_reset: assert property (p_ser_reset) // RQ11
        else $error("serial enable reset value wrong");

    property p_ser_off;
        @(posedge pclk) disable iff (!presetn)
        !ser_r[0] |=> serial.ser_powerdown && !serial.clk_gate_en && !serial.block_reset_n
                      && lmfc_cnt_r == '0;
    endproperty
    a_ser_off: assert property (p_ser_off) // RQ12
        else $error("serial block not held off while disabled");

    property p_apb_ready;
        @(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready)
        else $error("apb answer timing wrong");

endmodule

/* File: pkg/atdt_cfg.svh */
// register indices, field positions, reset values and bus widths of the block
`ifndef ATDT_CFG_SVH
`define ATDT_CFG_SVH

// ****************************************************************
// register indices, byte address is four times the index
// ****************************************************************
`define ATDT_IDX_TRIM    10'h07F
`define ATDT_IDX_DITH    10'h09D
`define ATDT_IDX_MARK    10'h160
`define ATDT_IDX_STAT    10'h161
`define ATDT_IDX_SER     10'h200

// ****************************************************************
// reset values
// ****************************************************************
`define ATDT_RST_TRIM    8'h00
`define ATDT_RST_DITH    8'h01
`define ATDT_RST_MARK    8'h00
`define ATDT_RST_SER     8'h01

// ****************************************************************
// field positions
// ****************************************************************
`define ATDT_DITH_ON_BIT   0
`define ATDT_DITH_AMP_BIT  1
`define ATDT_DITH_ERR_BIT  2
`define ATDT_MARK_EN_BIT   0
`define ATDT_SER_EN_BIT    0
`define ATDT_STAT_ACT_BIT  0
`define ATDT_STAT_LOAD_BIT 1
`define ATDT_STAT_RX_BIT   2

// ****************************************************************
// fixed values
// ****************************************************************
`define ATDT_CS_ADVERTISED 2'h0
`define ATDT_ADDR_W        12
`define ATDT_DATA_W        32

`endif

/* File: pkg/atdt_pkg.sv */
// types and helpers shared by the trim, dither and timestamp register block
package atdt_pkg;

    typedef struct packed {
        logic err_to_offset;
        logic amp_large;
        logic on;
    } atdt_dither_t;

    typedef struct packed {
        logic block_reset_n;
        logic ser_powerdown;
        logic clk_gate_en;
    } atdt_serial_t;

    // 8-bit samples sit left-justified in data[11:4]
    typedef struct packed {
        logic [11:0] data;
        logic        valid;
        logic        width8;
    } atdt_sample_t;

    function automatic logic [11:0] atdt_byte_addr(input logic [9:0] idx);
        return {idx, 2'b00};
    endfunction

endpackage

/* File: hw/atdt_marker.sv */
// sample path that places the delayed timestamp on each sample's lsb
`timescale 1ns/1ns
`include "atdt_cfg.svh"

module atdt_marker #(
    parameter int LAT = 4
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  enable,
    input  wire atdt_pkg::atdt_sample_t sample_in,
    input  wire logic                  timestamp_in,
    output atdt_pkg::atdt_sample_t      sample_out
);

    localparam int DEPTH = LAT + 1;

    logic [LAT-1:0] ts_pipe_r;
    logic           ts_dly;

    // ****************************************************************
    // timestamp delay, matches converter latency of sample_in
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ts_pipe_r <= '0;
        end else begin
            ts_pipe_r <= LAT'({ts_pipe_r, timestamp_in}); // RQ6
        end
    end

    assign ts_dly = ts_pipe_r[LAT-1];

    // ****************************************************************
    // lsb replacement
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_out <= '0;
        end else begin
            sample_out <= sample_in;
            if (enable) begin
                if (sample_in.width8) begin
                    sample_out.data[4] <= ts_dly; // RQ8
                end else begin
                    sample_out.data[0] <= ts_dly; // RQ9
                end
            end
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_mark_lsb12;
        @(posedge pclk) disable iff (!presetn)
        $past(enable) && !sample_out.width8 |-> sample_out.data[0] == $past(timestamp_in, DEPTH);
    endproperty
    a_mark_lsb12: assert property (p_mark_lsb12) // RQ6
        else $error("marker lsb not aligned in 12-bit mode");

    property p_mark_lsb8;
        @(posedge pclk) disable iff (!presetn)
        $past(enable) && sample_out.width8 |-> sample_out.data[4] == $past(timestamp_in, DEPTH);
    endproperty
    a_mark_lsb8: assert property (p_mark_lsb8) // RQ8
        else $error("marker lsb wrong in 8-bit mode");

    property p_mark_upper;
        @(posedge pclk) disable iff (!presetn)
        !sample_out.width8 |-> sample_out.data[11:1] == $past(sample_in.data[11:1]);
    endproperty
    a_mark_upper: assert property (p_mark_upper) // RQ9
        else $error("sample data above lsb corrupted");

    property p_mark_off;
        @(posedge pclk) disable iff (!presetn)
        !$past(enable) |-> sample_out.data == $past(sample_in.data);
    endproperty
    a_mark_off: assert property (p_mark_off) // RQ5
        else $error("sample altered while marker disabled");

endmodule

/* File: tb/adc_trim_dither_timestamp_regs_bench.sv */
// self-checking bench for the trim, dither, marker and serial enable registers
`timescale 1ns/1ns
`include "atdt_cfg.svh"

module adc_trim_dither_timestamp_regs_bench;
    localparam int         LAT    = 4;
    localparam int         KF     = 8;
    localparam logic [7:0] FUSE   = 8'h5A;
    localparam logic [11:0] A_TRIM = {`ATDT_IDX_TRIM, 2'b00};
    localparam logic [11:0] A_DITH = {`ATDT_IDX_DITH, 2'b00};
    localparam logic [11:0] A_MARK = {`ATDT_IDX_MARK, 2'b00};
    localparam logic [11:0] A_SER  = {`ATDT_IDX_SER, 2'b00};
    localparam logic [11:0] A_STAT = {`ATDT_IDX_STAT, 2'b00};

    logic                   pclk;
    logic                   presetn;
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [11:0]            paddr;
    logic [31:0]            pwdata;
    logic [3:0]             pstrb;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic [7:0]             trim_fuse_val;
    logic                   sync_receiver_on;
    logic                   sysref_pulse;
    atdt_pkg::atdt_sample_t sample_in;
    logic                   timestamp_in;
    logic [7:0]             trim_pins;
    atdt_pkg::atdt_dither_t dither;
    atdt_pkg::atdt_serial_t serial;
    atdt_pkg::atdt_sample_t sample_out;
    logic                   lmfc_boundary;
    logic [1:0]             ilas_cs_count;
    int                     n_mismatch;
    int                     tests_run;
    int                     pulses;

    atdt_regs #(
        .CONV_LAT (LAT),
        .K_FRAMES (KF)
    ) dut (
        .pclk                     (pclk),
        .presetn                  (presetn),
        .psel                     (psel),
        .penable                  (penable),
        .pwrite                   (pwrite),
        .paddr                    (paddr),
        .pwdata                   (pwdata),
        .pstrb                    (pstrb),
        .prdata                   (prdata),
        .pready                   (pready),
        .pslverr                  (pslverr),
        .trim_fuse_val            (trim_fuse_val),
        .sync_receiver_on         (sync_receiver_on),
        .sysref_pulse             (sysref_pulse),
        .sample_in                (sample_in),
        .timestamp_in             (timestamp_in),
        .input_b_termination_trim (trim_pins),
        .dither                   (dither),
        .serial                   (serial),
        .sample_out               (sample_out),
        .lmfc_boundary            (lmfc_boundary),
        .ilas_cs_count            (ilas_cs_count)
    );

    // ****************************************************************
    // clock and watchdog
    // ****************************************************************
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // whole run needs well under 2000 cycles
    initial begin
        repeat (4000) @(posedge pclk);
        $display("[ERR] t=%0t watchdog expired", $time);
        n_mismatch++;
        conclude();
    end

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // request held until pready is seen high at a rising edge
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk(32'(pready), 32'h1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        xfer(1'b1, a, d, 4'hF, q, e);
        chk(32'(e), 32'h0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] q;
        logic        e;
        xfer(1'b0, a, 32'h0, 4'hF, q, e);
        chk(q, exp);
        chk(32'(e), 32'(experr));
    endtask

    // ts set at edge j lands on the sample leaving after edge j+LAT+1
    task automatic run_marker(input logic en, input logic w8);
        logic [15:0] pat;
        logic [11:0] exp;
        logic        mk;
        pat = 16'hB38E;
        for (int k = 0; k < 24; k++) begin
            @(posedge pclk);
            timestamp_in <= pat[k % 16];
            sample_in    <= '{data: 12'hA50 ^ 12'(k), valid: 1'b1, width8: w8};
            @(negedge pclk);
            if (k >= LAT + 1) begin
                exp = 12'hA50 ^ 12'(k - 1);
                mk  = pat[(k - LAT - 1) % 16];
                chk(32'(sample_out.valid), 32'h1);
                if (!en) chk(32'(sample_out.data), 32'(exp));
                else if (w8) chk(32'(sample_out.data[11:4]), 32'({exp[11:5], mk}));
                else chk(32'(sample_out.data), 32'({exp[11:1], mk}));
            end
        end
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        n_mismatch = 0;
        tests_run = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        trim_fuse_val = FUSE;
        sync_receiver_on = 1'b1;
        sysref_pulse = 1'b0;
        sample_in = '0;
        timestamp_in = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);

        rd(A_TRIM, 32'(FUSE), 1'b0);
        rd(A_DITH, 32'h01, 1'b0);
        rd(A_MARK, 32'h00, 1'b0);
        rd(A_SER, 32'h01, 1'b0);
        rd(A_STAT, 32'h03, 1'b0);
        @(negedge pclk);
        chk(32'(trim_pins), 32'(FUSE));
        chk(32'(dither), 32'h1);
        chk(32'(serial), 32'h5);
        $display("test reset values done");

        wr(A_TRIM, 32'hC3);
        rd(A_TRIM, 32'hC3, 1'b0);
        @(negedge pclk);
        chk(32'(trim_pins), 32'hC3);
        for (int d = 0; d < 8; d++) begin
            wr(A_DITH, 32'(d));
            rd(A_DITH, 32'(d), 1'b0);
            @(negedge pclk);
            chk(32'(dither), 32'(d));
        end
        begin
            logic [31:0] q;
            logic        e;
            // strobe low leaves the register alone
            xfer(1'b1, A_DITH, 32'h00, 4'h0, q, e);
            chk(32'(e), 32'h0);
        end
        rd(A_DITH, 32'h07, 1'b0);
        wr(A_DITH, 32'h00);
        rd(A_DITH, 32'h00, 1'b0);
        $display("test register access done");

        rd(12'h004, 32'h0, 1'b1);
        rd(12'h275, 32'h0, 1'b1);
        wr(A_MARK, 32'h00);
        $display("test unmapped access done");

        wr(A_SER, 32'h00);
        rd(A_SER, 32'h00, 1'b0);
        pulses = 0;
        for (int c = 0; c < 3 * KF; c++) begin
            @(posedge pclk);
            sysref_pulse <= (c % 5 == 0);
            @(negedge pclk);
            pulses += int'(lmfc_boundary === 1'b1);
        end
        chk(32'(serial), 32'h2);
        chk(32'(pulses), 32'h0);
        wr(A_SER, 32'h01);
        @(posedge pclk);
        sysref_pulse <= 1'b1;
        @(posedge pclk);
        sysref_pulse <= 1'b0;
        pulses = 0;
        // window includes the third boundary, one frame count after the second
        repeat (3 * KF + 1) begin
            @(negedge pclk);
            pulses += int'(lmfc_boundary === 1'b1);
        end
        chk(32'(serial), 32'h5);
        chk(32'(pulses), 32'h3);
        $display("test serial enable done");

        run_marker(1'b0, 1'b0);
        wr(A_MARK, 32'h01);
        rd(A_MARK, 32'h01, 1'b0);
        sync_receiver_on <= 1'b0;
        rd(A_STAT, 32'h07, 1'b0);
        sync_receiver_on <= 1'b1;
        rd(A_STAT, 32'h03, 1'b0);
        run_marker(1'b1, 1'b0);
        run_marker(1'b1, 1'b1);
        chk(32'(ilas_cs_count), 32'h0);
        $display("test sample marker done");
        conclude();
    end
endmodule
